// [testbench/dpmhc_host_chk.sv]
`timescale 1ns/10ps
module dpmhc_host_chk (
    input wire logic       mclk_i,
    input wire logic       nrst_i,
    input wire logic       req_i,
    input wire logic       write_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       busy_o,
    input wire logic       done_o,
    input wire logic [7:0] muxed_bus_lines_o,
    input wire logic       muxed_bus_lines_oe_o,
    input wire logic       port_sel_n_o,
    input wire logic       out_en_n_o,
    input wire logic       wr_strobe_n_o
);
    logic [7:0] a_q;
    logic [7:0] w_q;
    always_ff @(posedge mclk_i) begin
        if (req_i && !busy_o) begin
            a_q <= addr_i;
            w_q <= wdata_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_take; req_i && !busy_o; endsequence
    sequence s_take_rd; req_i && !busy_o && !write_i; endsequence
    sequence s_take_wr; req_i && !busy_o && write_i; endsequence
    sequence s_rd_end; $rose(out_en_n_o) ##1 $rose(port_sel_n_o); endsequence
    sequence s_wr_end; $rose(wr_strobe_n_o) ##1 $rose(port_sel_n_o); endsequence
    a_done_time: assert property (s_take |-> ##11 done_o)
        else $error("done late or missing");
    a_busy_span: assert property (
        s_take |=> busy_o[*8] ##1 busy_o[*2] ##1 !busy_o)
        else $error("busy span wrong");
    a_rd_order: assert property (s_take_rd |->
        ##3 $fell(port_sel_n_o) ##1 $fell(out_en_n_o) ##4 s_rd_end)
        else $error("read strobes out of order");
    a_wr_order: assert property (s_take_wr |->
        ##3 $fell(port_sel_n_o) ##1 $fell(wr_strobe_n_o) ##4 s_wr_end)
        else $error("write strobes out of order");
    a_strobe_excl: assert property (
        !wr_strobe_n_o |-> out_en_n_o)
        else $error("both strobes low");
    a_addr_at_sel: assert property ($fell(port_sel_n_o) |->
        muxed_bus_lines_oe_o && muxed_bus_lines_o == a_q)
        else $error("bad address");
    // Data must already stand when the write strobe falls
    a_wr_data: assert property (s_take_wr |-> ##4
        (muxed_bus_lines_oe_o && muxed_bus_lines_o == w_q)[*5])
        else $error("bad data");
    a_rd_release: assert property (
        !out_en_n_o |-> !muxed_bus_lines_oe_o)
        else $error("host drives during read");
    a_sel_held: assert property (
        !out_en_n_o || !wr_strobe_n_o |-> !port_sel_n_o)
        else $error("strobe without select");
endmodule : dpmhc_host_chk
bind dpmhc_host dpmhc_host_chk chk (.*);

// [testbench/dpmhc_ram_model.sv]
`timescale 1ns/10ps
// ----
// One port of the shared byte array, timed by strobe edges only
// ----
module dpmhc_ram_model (
    input  wire logic       sel_n_i,
    input  wire logic       oe_n_i,
    input  wire logic       we_n_i,
    input  wire logic [7:0] bus_i,
    output logic      [7:0] bus_o,
    output logic            bus_oe_o
);
    logic [7:0] mem [256];
    logic [7:0] addr_q;
    initial foreach (mem[i]) mem[i] = 8'h00;
    // Own latch, so later bus traffic cannot move the address
    always @(negedge sel_n_i) addr_q = bus_i;
    // Store on the closing edge, when the data byte has settled
    always @(posedge we_n_i) if (!sel_n_i) mem[addr_q] = bus_i;
    // Driven from this port's own three strobes alone
    assign bus_oe_o = !sel_n_i && !oe_n_i && we_n_i;
    assign bus_o = mem[addr_q];
endmodule : dpmhc_ram_model

// [testbench/dual_port_muxed_bus_ram_test.sv]
`timescale 1ns/10ps
module dual_port_muxed_bus_ram_test;
    logic mclk_i = 0, nrst_i = 0, req_i = 0, write_i = 0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, last_q = 8'h00;
    logic busy_o, done_o, port_sel_n_o, out_en_n_o, wr_strobe_n_o;
    logic [7:0] rdata_o, muxed_bus_lines_o, d_o;
    logic muxed_bus_lines_oe_o, d_oe;
    wire logic [7:0] muxed_bus_lines_i;
    int bad_count = 0, total_checks = 0, ref_mem[256];
    // Released lines show a value that changes each cycle
    assign muxed_bus_lines_i = muxed_bus_lines_oe_o ? muxed_bus_lines_o
                             : d_oe ? d_o : ~last_q;
    always @(posedge mclk_i) last_q <= muxed_bus_lines_i;
    initial forever #12.5 mclk_i = ~mclk_i;
    dpmhc_host dut (.*);
    dpmhc_ram_model ram (.sel_n_i(port_sel_n_o), .oe_n_i(out_en_n_o),
        .we_n_i(wr_strobe_n_o), .bus_i(muxed_bus_lines_i), .bus_o(d_o),
        .bus_oe_o(d_oe));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // A poke is a request while busy; it must leave no trace
    task access(input logic w, input logic [7:0] a, input logic [7:0] d,
                input bit poke);
        write_i = w;
        addr_i = a;
        wdata_i = d;
        req_i = 1;
        // Done rises after the tenth edge past the taking edge
        for (int i = 0; i < 11; i++) begin
            @(posedge mclk_i);
            #1;
            req_i = poke && i == 1;
            write_i = poke ? 1'b1 : w;
            addr_i = poke ? a ^ 8'h01 : a;
        end
        check({7'h00, done_o}, 8'h01);
        if (w) ref_mem[a] = d;
        else check(rdata_o, 8'(ref_mem[a]));
    endtask : access
    initial begin
        int s;
        logic [7:0] a;
        s = $urandom(38);
        foreach (ref_mem[i]) ref_mem[i] = 0;
        repeat (16) @(posedge mclk_i);
        #1 nrst_i = 1;
        // Ends first, then random mixed traffic on few addresses
        for (int i = 0; i < 80; i++) begin
            a = i < 4 ? {8{i[0]}} : 8'($urandom_range(15));
            access(i < 2 ? 1'b1 : i < 4 ? 1'b0 : 1'($urandom_range(1)),
                   a, 8'($urandom), $urandom_range(4) == 0);
        end
        finish_test;
    end
    initial begin
        #50000;
        bad_count++;
        finish_test;
    end
endmodule : dual_port_muxed_bus_ram_test

// [verilog/dpmhc_consts.svh]
`ifndef DPMHC_CONSTS_SVH
`define DPMHC_CONSTS_SVH

// Bus clock timing, in ns, and derived cycle counts at 40 MHz
`define DPMHC_CLK_PERIOD_NS   25
`define DPMHC_T_ADDR_NS       50
`define DPMHC_T_ADDR_CYC \
    ((`DPMHC_T_ADDR_NS + `DPMHC_CLK_PERIOD_NS - 1) / `DPMHC_CLK_PERIOD_NS)
`define DPMHC_T_STROBE_NS     100
`define DPMHC_T_STROBE_CYC \
    ((`DPMHC_T_STROBE_NS + `DPMHC_CLK_PERIOD_NS - 1) / `DPMHC_CLK_PERIOD_NS)
`define DPMHC_T_RECOVER_NS    50
`define DPMHC_T_RECOVER_CYC \
    ((`DPMHC_T_RECOVER_NS + `DPMHC_CLK_PERIOD_NS - 1) / `DPMHC_CLK_PERIOD_NS)

// Field widths
`define DPMHC_BYTE_W          8
`define DPMHC_MUX_HALF_W      4
`define DPMHC_CNT_W           4

// Reset levels
`define DPMHC_STROBE_IDLE     1'b1
`define DPMHC_BYTE_ZERO       8'h00

`endif

// [verilog/dpmhc_host.sv]
`timescale 1ns/10ps
`include "dpmhc_consts.svh"

// ----------------------------------------------------------------------
// Host controller for one port of a muxed-bus dual-port RAM
// ----------------------------------------------------------------------
module dpmhc_host (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        req_i,
    input  wire logic        write_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [7:0]       rdata_o,
    input  wire logic [7:0]  muxed_bus_lines_i,
    output logic [7:0]       muxed_bus_lines_o,
    output logic             muxed_bus_lines_oe_o,
    output logic             port_sel_n_o,
    output logic             out_en_n_o,
    output logic             wr_strobe_n_o
);

    // ------------------------------------------------------------------
    // Input synchronisers and request capture
    // ------------------------------------------------------------------
    logic [7:0]             bus_s1_q;
    logic [7:0]             bus_s2_q;
    dpmhc_pkg::dpmhc_state_e state_q;
    dpmhc_pkg::dpmhc_state_e state_d;
    logic [3:0]             cnt_q;
    logic [3:0]             cnt_d;
    logic                   wr_q;
    logic                   wr_d;
    logic [7:0]             addr_q;
    logic [7:0]             addr_d;
    logic [7:0]             wdat_q;
    logic [7:0]             wdat_d;
    logic                   phase_data_q;
    logic                   phase_data_d;
    logic                   oe_q;
    logic                   oe_d;
    logic                   sel_n_q;
    logic                   sel_n_d;
    logic                   ren_n_q;
    logic                   ren_n_d;
    logic                   wen_n_q;
    logic                   wen_n_d;
    logic                   busy_q;
    logic                   busy_d;
    logic                   done_q;
    logic                   done_d;
    logic [7:0]             rdata_q;
    logic [7:0]             rdata_d;

    function automatic logic [3:0] load_count(input logic [3:0] n);
        load_count = (n > 4'h1) ? (n - 4'h1) : 4'h0;
    endfunction : load_count

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            bus_s1_q <= `DPMHC_BYTE_ZERO;
            bus_s2_q <= `DPMHC_BYTE_ZERO;
        end else begin
            bus_s1_q <= muxed_bus_lines_i;
            bus_s2_q <= bus_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Strobes are sequenced so select falls while the address is stable,
    // and the bus is released on the same edge that output enable falls.
    always_comb begin
        state_d      = state_q;
        cnt_d        = cnt_q;
        wr_d         = wr_q;
        addr_d       = addr_q;
        wdat_d       = wdat_q;
        phase_data_d = phase_data_q;
        oe_d         = oe_q;
        sel_n_d      = sel_n_q;
        ren_n_d      = ren_n_q;
        wen_n_d      = wen_n_q;
        busy_d       = busy_q;
        done_d       = 1'b0;
        rdata_d      = rdata_q;
        unique case (state_q)
            dpmhc_pkg::DPMHC_IDLE: begin
                if (req_i) begin
                    wr_d         = write_i;
                    // Address passes through whole: write ownership and the
                    // status byte stay a convention of the master's software
                    addr_d       = addr_i;
                    wdat_d       = wdata_i;
                    phase_data_d = 1'b0;
                    oe_d         = 1'b1;
                    busy_d       = 1'b1;
                    cnt_d        = load_count(4'(`DPMHC_T_ADDR_CYC));
                    state_d      = dpmhc_pkg::DPMHC_ADDR;
                end
            end
            dpmhc_pkg::DPMHC_ADDR: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    sel_n_d      = 1'b0;
                    phase_data_d = 1'b1;
                    state_d = dpmhc_pkg::DPMHC_SELECT;
                end
            end
            dpmhc_pkg::DPMHC_SELECT: begin
                cnt_d        = load_count(4'(`DPMHC_T_STROBE_CYC));
                if (wr_q) begin
                    wen_n_d = 1'b0;
                end else begin
                    oe_d    = 1'b0;
                    ren_n_d = 1'b0;
                end
                state_d = dpmhc_pkg::DPMHC_STROBE;
            end
            dpmhc_pkg::DPMHC_STROBE: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    ren_n_d = 1'b1;
                    wen_n_d = 1'b1;
                    if (!wr_q) begin
                        rdata_d = bus_s2_q;
                    end
                    state_d = dpmhc_pkg::DPMHC_RELEASE;
                end
            end
            dpmhc_pkg::DPMHC_RELEASE: begin
                sel_n_d = 1'b1;
                oe_d    = 1'b0;
                cnt_d   = load_count(4'(`DPMHC_T_RECOVER_CYC));
                state_d = dpmhc_pkg::DPMHC_RECOVER;
            end
            dpmhc_pkg::DPMHC_RECOVER: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    busy_d  = 1'b0;
                    done_d  = 1'b1;
                    state_d = dpmhc_pkg::DPMHC_IDLE;
                end
            end
            default: begin
                state_d = dpmhc_pkg::DPMHC_IDLE;
                sel_n_d = 1'b1;
                ren_n_d = 1'b1;
                wen_n_d = 1'b1;
                oe_d    = 1'b0;
                busy_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            state_q      <= dpmhc_pkg::DPMHC_IDLE;
            cnt_q        <= 4'h0;
            wr_q         <= 1'b0;
            addr_q       <= `DPMHC_BYTE_ZERO;
            wdat_q       <= `DPMHC_BYTE_ZERO;
            phase_data_q <= 1'b0;
            oe_q         <= 1'b0;
            sel_n_q      <= `DPMHC_STROBE_IDLE;
            ren_n_q      <= `DPMHC_STROBE_IDLE;
            wen_n_q      <= `DPMHC_STROBE_IDLE;
            busy_q       <= 1'b0;
            done_q       <= 1'b0;
            rdata_q      <= `DPMHC_BYTE_ZERO;
        end else begin
            state_q      <= state_d;
            cnt_q        <= cnt_d;
            wr_q         <= wr_d;
            addr_q       <= addr_d;
            wdat_q       <= wdat_d;
            phase_data_q <= phase_data_d;
            oe_q         <= oe_d;
            sel_n_q      <= sel_n_d;
            ren_n_q      <= ren_n_d;
            wen_n_q      <= wen_n_d;
            busy_q       <= busy_d;
            done_q       <= done_d;
            rdata_q      <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Address/data selectors
    // ------------------------------------------------------------------
    // Registered selectors add one cycle, so the phase flips a cycle
    // ahead of the strobe that samples the data half.
    dpmhc_mux4 u_mux_lo (
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .sel_data_i (phase_data_q),
        .addr_i     (addr_q[3:0]),
        .data_i     (wdat_q[3:0]),
        .out_o      (muxed_bus_lines_o[3:0])
    );

    dpmhc_mux4 u_mux_hi (
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .sel_data_i (phase_data_q),
        .addr_i     (addr_q[7:4]),
        .data_i     (wdat_q[7:4]),
        .out_o      (muxed_bus_lines_o[7:4])
    );

    assign muxed_bus_lines_oe_o = oe_q;
    assign port_sel_n_o         = sel_n_q;
    assign out_en_n_o           = ren_n_q;
    assign wr_strobe_n_o        = wen_n_q;
    assign busy_o               = busy_q;
    assign done_o               = done_q;
    assign rdata_o              = rdata_q;

endmodule : dpmhc_host

// [verilog/dpmhc_mux4.sv]
`timescale 1ns/10ps
`include "dpmhc_consts.svh"

// Registered 2-input selector for one 4-bit half of the shared lines
module dpmhc_mux4 (
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic       sel_data_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [3:0] data_i,
    output logic      [3:0] out_o
);

    logic [3:0] out_d;
    logic [3:0] out_q;

    always_comb begin
        out_d = sel_data_i ? data_i : addr_i;
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            out_q <= 4'h0;
        end else begin
            out_q <= out_d;
        end
    end

    assign out_o = out_q;

endmodule : dpmhc_mux4

// [verilog/dpmhc_pkg.sv]
package dpmhc_pkg;

    typedef enum logic [5:0] {
        DPMHC_IDLE    = 6'b000001,
        DPMHC_ADDR    = 6'b000010,
        DPMHC_SELECT  = 6'b000100,
        DPMHC_STROBE  = 6'b001000,
        DPMHC_RELEASE = 6'b010000,
        DPMHC_RECOVER = 6'b100000
    } dpmhc_state_e;

    typedef logic [7:0] dpmhc_byte_t;

endpackage : dpmhc_pkg
